// [rtl/atb_sequencer.v]
// Acquisition sequencer: sample clocks, record framing, trigger interval measurement.
`timescale 1ns/10ps
`include "atb_consts.vh"
module atb_sequencer (
    input  wire                   ref_clk,
    input  wire                   rst_n,
    input  wire                   rearm,
    input  wire [`ATB_DIV_W-1:0]  div_ratio,
    input  wire [`ATB_CNT_W-1:0]  pre_count,
    input  wire [`ATB_CNT_W-1:0]  post_count,
    input  wire                   trig_in,
    input  wire                   stretch_done_in,
    output reg                    sample_clk_reg,
    output reg                    trig_arm_reg,
    output reg                    acq_done_reg,
    output reg                    stretch_pulse_reg,
    output reg  [`ATB_MEAS_W-1:0] interval_reg,
    output reg                    interval_valid_reg
);
    reg [2:0]             state_reg;
    reg [2:0]             state_next;
    reg [`ATB_CNT_W-1:0]  pre_cnt_reg;
    reg [`ATB_CNT_W-1:0]  post_cnt_reg;
    reg [`ATB_MEAS_W-1:0] meas_reg;
    reg                   meas_run_reg;
    reg                   trig_s1_reg;
    reg                   trig_s2_reg;
    reg                   trig_s3_reg;
    reg                   sd_s1_reg;
    reg                   sd_s2_reg;
    reg                   sd_s3_reg;
    wire                  tick;
    wire                  run;
    wire                  trig_rise;
    wire                  sd_rise;
    wire                  pre_reached;
    wire                  post_empty;
    wire                  trig_taken;
    wire                  pulse_end;
    wire                  meas_full;
    wire                  meas_stop;
    wire                  pre_step;
    wire                  post_step;

    // Trigger and stretcher status arrive asynchronously and are synchronised first.
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            trig_s1_reg <= 1'b0;
            trig_s2_reg <= 1'b0;
            trig_s3_reg <= 1'b0;
            sd_s1_reg   <= 1'b0;
            sd_s2_reg   <= 1'b0;
            sd_s3_reg   <= 1'b0;
        end else begin
            trig_s1_reg <= trig_in;
            trig_s2_reg <= trig_s1_reg;
            trig_s3_reg <= trig_s2_reg;
            sd_s1_reg   <= stretch_done_in;
            sd_s2_reg   <= sd_s1_reg;
            sd_s3_reg   <= sd_s2_reg;
        end
    end

    assign trig_rise = trig_s2_reg & ~trig_s3_reg;
    assign sd_rise   = sd_s2_reg & ~sd_s3_reg;
    assign run       = (state_reg == `ATB_ST_PRE) || (state_reg == `ATB_ST_ARMED) ||
                       (state_reg == `ATB_ST_POST);
    assign pre_reached = (pre_cnt_reg >= pre_count);
    assign post_empty  = (post_cnt_reg == `ATB_ZERO16);
    assign trig_taken  = (state_reg == `ATB_ST_ARMED) && trig_rise;
    assign pulse_end   = stretch_pulse_reg && tick;
    assign meas_full   = (meas_reg == `ATB_MEAS_MAX);
    assign meas_stop   = meas_run_reg && sd_rise;
    assign pre_step    = (state_reg == `ATB_ST_PRE) && tick && !pre_reached;
    assign post_step   = (state_reg == `ATB_ST_POST) && tick && !post_empty;

    atb_rate_div u_div (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .run       (run),
        .div_ratio (div_ratio),
        .tick_reg  (tick)
    );

    always @* begin
        state_next = state_reg;
        case (state_reg)
            `ATB_ST_IDLE: begin
                if (rearm) begin
                    state_next = `ATB_ST_PRE;
                end
            end
            `ATB_ST_PRE: begin
                if (pre_cnt_reg >= pre_count) begin
                    state_next = `ATB_ST_ARMED;
                end
            end
            `ATB_ST_ARMED: begin
                if (trig_rise) begin
                    state_next = `ATB_ST_POST;
                end
            end
            `ATB_ST_POST: begin
                if (post_cnt_reg == `ATB_ZERO16) begin
                    state_next = `ATB_ST_DONE;
                end
            end
            `ATB_ST_DONE: begin
                if (rearm) begin
                    state_next = `ATB_ST_PRE;
                end
            end
            default: begin
                state_next = `ATB_ST_IDLE;
            end
        endcase
    end

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            state_reg <= `ATB_ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // The converter multiplies this tick by ten for the top rate.
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            sample_clk_reg <= 1'b0;
        end else begin
            sample_clk_reg <= tick & run;
        end
    end

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            trig_arm_reg <= 1'b0;
        end else begin
            trig_arm_reg <= (state_next == `ATB_ST_ARMED);
        end
    end

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            pre_cnt_reg  <= `ATB_ZERO16;
            post_cnt_reg <= `ATB_ZERO16;
        end else if (rearm) begin
            pre_cnt_reg  <= `ATB_ZERO16;
            post_cnt_reg <= post_count;
        end else begin
            if (pre_step) begin
                pre_cnt_reg <= pre_cnt_reg + `ATB_ONE16;
            end
            if (post_step) begin
                post_cnt_reg <= post_cnt_reg - `ATB_ONE16;
            end
        end
    end

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            acq_done_reg <= 1'b0;
        end else if (rearm) begin
            acq_done_reg <= 1'b0;
        end else if (state_next == `ATB_ST_DONE) begin
            acq_done_reg <= 1'b1;
        end
    end

    // Pulse spans from the trigger to the next sample tick.
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            stretch_pulse_reg <= 1'b0;
        end else if (rearm) begin
            stretch_pulse_reg <= 1'b0;
        end else if (trig_taken) begin
            stretch_pulse_reg <= 1'b1;
        end else if (pulse_end) begin
            stretch_pulse_reg <= 1'b0;
        end
    end

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            meas_reg     <= `ATB_ZERO16;
            meas_run_reg <= 1'b0;
        end else if (rearm) begin
            meas_reg     <= `ATB_ZERO16;
            meas_run_reg <= 1'b0;
        end else if (!trig_taken && pulse_end) begin
            meas_reg     <= `ATB_ZERO16;
            meas_run_reg <= 1'b1;
        end else if (meas_run_reg) begin
            if (sd_rise) begin
                meas_run_reg <= 1'b0;
            end else if (!meas_full) begin
                // Saturates rather than wraps if the stretcher never answers.
                meas_reg <= meas_reg + `ATB_ONE16;
            end
        end
    end

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            interval_reg       <= `ATB_ZERO16;
            interval_valid_reg <= 1'b0;
        end else if (rearm) begin
            interval_valid_reg <= 1'b0;
        end else if (meas_stop) begin
            interval_reg       <= meas_reg;
            interval_valid_reg <= 1'b1;
        end
    end
endmodule

// [common/atb_consts.vh]
// Constants for the acquisition time base sequencer.
`ifndef ATB_CONSTS_VH
`define ATB_CONSTS_VH
`define ATB_CNT_W      16
`define ATB_DIV_W      16
`define ATB_MEAS_W     16
`define ATB_ZERO16     16'h0000
`define ATB_ONE16      16'h0001
`define ATB_MEAS_MAX   16'hFFFF
`define ATB_ST_IDLE    3'h0
`define ATB_ST_PRE     3'h1
`define ATB_ST_ARMED   3'h2
`define ATB_ST_POST    3'h3
`define ATB_ST_DONE    3'h4
`define ATB_REF_MHZ    8'h64
`define ATB_CONV_MULT  4'hA
`endif

// [rtl/atb_rate_div.v]
// Programmable sample clock divider producing one-cycle sample ticks.
`timescale 1ns/10ps
`include "atb_consts.vh"
module atb_rate_div (
    input  wire                  ref_clk,
    input  wire                  rst_n,
    input  wire                  run,
    input  wire [`ATB_DIV_W-1:0] div_ratio,
    output reg                   tick_reg
);
    reg [`ATB_DIV_W-1:0] cnt_reg;

    // A ratio of zero or one gives a tick every cycle, the base rate.
    always @(posedge ref_clk) begin
        if (!rst_n || !run) begin
            cnt_reg  <= `ATB_ZERO16;
            tick_reg <= 1'b0;
        end else if (cnt_reg + `ATB_ONE16 >= div_ratio) begin
            cnt_reg  <= `ATB_ZERO16;
            tick_reg <= 1'b1;
        end else begin
            cnt_reg  <= cnt_reg + `ATB_ONE16;
            tick_reg <= 1'b0;
        end
    end
endmodule

// [bench/atb_sequencer_properties.sv]
// Checker for the sequencer's output relations.
`timescale 1ns/10ps
`include "atb_consts.vh"
module atb_sequencer_properties (
    input wire logic                   ref_clk,
    input wire logic                   rst_n,
    input wire logic                   rearm,
    input wire logic                   sample_clk_reg,
    input wire logic                   trig_arm_reg,
    input wire logic                   acq_done_reg,
    input wire logic                   stretch_pulse_reg,
    input wire logic [`ATB_MEAS_W-1:0] interval_reg,
    input wire logic                   interval_valid_reg
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence s_halted;
        !trig_arm_reg ##1 !sample_clk_reg;
    endsequence
    a_arm_done_excl: assert property (trig_arm_reg |-> !acq_done_reg)
        else $error("arm and done high together");
    a_done_holds: assert property (acq_done_reg && !rearm |=> acq_done_reg)
        else $error("done dropped without rearm");
    a_clk_stops: assert property (acq_done_reg && !rearm |=> !sample_clk_reg)
        else $error("sample clock after done");
    a_done_step: assert property ($rose(acq_done_reg) |-> s_halted)
        else $error("done without halt");
    a_valid_holds: assert property (interval_valid_reg && !rearm |=>
        interval_valid_reg && $stable(interval_reg))
        else $error("interval count not held");
    a_arm_to_pulse: assert property ($fell(trig_arm_reg) && !$past(rearm) |->
        stretch_pulse_reg)
        else $error("no stretch pulse on trigger");
    a_rearm_clears: assert property (rearm |=> !acq_done_reg && !interval_valid_reg)
        else $error("rearm did not clear");
    a_valid_not_armed: assert property ($rose(interval_valid_reg) |-> !trig_arm_reg)
        else $error("interval frozen while armed");
endmodule
bind atb_sequencer atb_sequencer_properties u_props (.ref_clk(ref_clk), .rst_n(rst_n),
    .rearm(rearm), .sample_clk_reg(sample_clk_reg), .trig_arm_reg(trig_arm_reg),
    .acq_done_reg(acq_done_reg), .stretch_pulse_reg(stretch_pulse_reg),
    .interval_reg(interval_reg), .interval_valid_reg(interval_valid_reg));

// [bench/atb_trig_model.sv]
// Trigger logic and interval stretcher model.
`timescale 1ns/10ps
module atb_trig_model #(
    parameter STRETCH = 4
) (
    input  wire logic ref_clk,
    input  wire logic fire,
    input  wire logic trig_arm_reg,
    input  wire logic stretch_pulse_reg,
    output logic      trig_in,
    output logic      stretch_done_in
);
    integer wid = 0;
    integer cnt = 0;
    initial trig_in = 1'b0;
    initial stretch_done_in = 1'b0;
    // A trigger only leaves while armed; a wider stretch pulse gives a slower answer.
    always @(posedge ref_clk) begin
        trig_in <= trig_arm_reg && fire;
        if (stretch_pulse_reg) begin
            wid <= wid + 1;
            cnt <= 0;
            stretch_done_in <= 1'b0;
        end else if (wid != 0) begin
            cnt <= cnt + 1;
            if (cnt == wid * STRETCH) begin
                stretch_done_in <= 1'b1;
                wid <= 0;
            end
        end
    end
endmodule

// [bench/atb_sequencer_tb.sv]
// Testbench for the acquisition sequencer.
`timescale 1ns/10ps
module atb_sequencer_tb;
    reg         ref_clk = 1'b0, rst_n = 1'b0, rearm = 1'b0, fire = 1'b0;
    reg  [15:0] div_ratio = 16'h0001, pre_count = 16'h0000, post_count = 16'h0000;
    wire        trig_in, stretch_done_in, sample_clk_reg, trig_arm_reg;
    wire        acq_done_reg, stretch_pulse_reg, interval_valid_reg;
    wire [15:0] interval_reg;
    integer     errors = 0, compares = 0, cycles = 0;
    atb_sequencer dut (.ref_clk(ref_clk), .rst_n(rst_n), .rearm(rearm),
        .div_ratio(div_ratio), .pre_count(pre_count), .post_count(post_count),
        .trig_in(trig_in), .stretch_done_in(stretch_done_in),
        .sample_clk_reg(sample_clk_reg), .trig_arm_reg(trig_arm_reg),
        .acq_done_reg(acq_done_reg), .stretch_pulse_reg(stretch_pulse_reg),
        .interval_reg(interval_reg), .interval_valid_reg(interval_valid_reg));
    atb_trig_model model (.ref_clk(ref_clk), .fire(fire), .trig_arm_reg(trig_arm_reg),
        .stretch_pulse_reg(stretch_pulse_reg), .trig_in(trig_in),
        .stretch_done_in(stretch_done_in));
    initial forever #2 ref_clk = ~ref_clk;
    task finish_test;
        $display("compares=%0d errors=%0d", compares, errors);
        if (errors == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors = errors + 1;
            finish_test;
        end
    end
    task check(input [15:0] got, input [15:0] exp);
        compares = compares + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Ticks are counted by phase, so a tick on the arming edge is not double counted.
    task run_record(input [15:0] d, input [15:0] p, input [15:0] q, input integer w);
        integer n, k, s, seen;
        @(posedge ref_clk);
        div_ratio <= d; pre_count <= p; post_count <= q; fire <= 1'b0; rearm <= 1'b1;
        @(posedge ref_clk);
        rearm <= 1'b0;
        #1 n = sample_clk_reg; k = 0;
        while (!trig_arm_reg && k < 5000) begin
            @(posedge ref_clk); #1 k = k + 1;
            if (!trig_arm_reg) n = n + sample_clk_reg;
        end
        check(n[15:0], p);
        repeat (w) @(posedge ref_clk);
        @(posedge ref_clk);
        fire <= 1'b1;
        n = 0; k = 0; s = 0; seen = 0;
        // The pulse on the edge that takes the trigger belongs to the armed phase.
        while (!acq_done_reg && k < 5000) begin
            @(posedge ref_clk); #1 k = k + 1;
            if (seen && !acq_done_reg) n = n + sample_clk_reg;
            if (!trig_arm_reg) seen = 1;
            s = s + stretch_pulse_reg;
        end
        check(n[15:0], q);
        check({15'h0000, s != 0 && s <= d}, 16'h0001);
        n = 0;
        for (k = 0; k < 40 && !interval_valid_reg; k = k + 1) begin
            @(posedge ref_clk); #1 n = n + sample_clk_reg;
        end
        check({14'h0000, acq_done_reg, interval_valid_reg}, 16'h0003);
        check(n[15:0], 16'h0000);
        n = interval_reg;
        check({15'h0000, interval_reg != 16'h0000}, 16'h0001);
        repeat (4) @(posedge ref_clk);
        #1 check(interval_reg, n[15:0]);
        $display("test done div=%h pre=%h post=%h errors=%0d", d, p, q, errors);
    endtask
    initial begin
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        run_record(16'h0001, 16'h0000, 16'h0000, 2);
        run_record(16'h0001, 16'h0005, 16'h0003, 0);
        run_record(16'h0003, 16'h0004, 16'h0006, 7);
        run_record(16'h0002, 16'h0002, 16'h0001, 1);
        finish_test;
    end
endmodule
